// file: src/pctl_regs.sv
// protection control register with self-clearing commands
// assumes a byte register port from the serial bus slave, same clock
`timescale 1ns/100ps
module pctl_regs (
	input wire logic core_clk,
	input wire logic reset,
	input pctl_pkg::pctl_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [1:0] cipher_policy,
	input wire logic receiver_key_ready,
	input wire logic auth_complete,
	input wire logic authenticated,
	output pctl_pkg::pctl_cmd_t cmd,
	output logic auth_enabled,
	output logic cipher_active,
	output pctl_pkg::pctl_video_t video_mode
);
	import pctl_pkg::*;
	logic hit_wr;
	logic list_ok_reg;
	logic key_ok_reg;
	logic ciph_en_reg;
	logic auth_en_reg;
	logic ciph_off_reg;
	logic ready_d_reg;
	logic ready_rise;
	logic always_pol;
	logic [7:0] rdata_reg;
	logic [7:0] rd_next;
	pctl_cmd_t cmd_reg;

	assign hit_wr = bus.wr && (bus.addr == PCTL_ADDR);
	assign ready_rise = receiver_key_ready && !ready_d_reg;
	assign always_pol = (cipher_policy == POL_ALWAYS);

	always_ff @(posedge core_clk)
	begin
		if (reset)
			ready_d_reg <= 1'b0;
		else
			ready_d_reg <= receiver_key_ready;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			cmd_reg <= '0;
		else
		begin
			cmd_reg.engine_reset <= hit_wr && bus.wdata[BIT_RESET];
			cmd_reg.auth_start <= hit_wr && bus.wdata[BIT_AUTH_EN] && !bus.wdata[BIT_RESET];
			cmd_reg.auth_disable <= hit_wr && bus.wdata[BIT_AUTH_DIS];
			cmd_reg.cipher_off <= hit_wr && bus.wdata[BIT_CIPH_OFF];
			cmd_reg.list_approved <= list_ok_reg;
			cmd_reg.key_approved <= key_ok_reg;
		end
	end
	assign cmd = cmd_reg;

	// repeater list approval held until completion
	always_ff @(posedge core_clk)
	begin
		if (reset)
			list_ok_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_RESET])
			list_ok_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_LIST_OK])
			list_ok_reg <= 1'b1;
		else if (auth_complete)
			list_ok_reg <= 1'b0;
	end

	// key approval cleared by the rising edge of key ready, zero write ignored
	always_ff @(posedge core_clk)
	begin
		if (reset)
			key_ok_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_RESET])
			key_ok_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_KEY_OK])
			key_ok_reg <= 1'b1;
		else if (ready_rise)
			key_ok_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			ciph_en_reg <= PCTL_RESET[BIT_CIPH_EN];
		else if (hit_wr && bus.wdata[BIT_RESET])
			ciph_en_reg <= 1'b0;
		else if (hit_wr && !always_pol)
			ciph_en_reg <= bus.wdata[BIT_CIPH_EN];
	end

	// cipher off holds until encryption re-enabled
	always_ff @(posedge core_clk)
	begin
		if (reset)
			ciph_off_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_CIPH_OFF])
			ciph_off_reg <= 1'b1;
		else if (hit_wr && bus.wdata[BIT_CIPH_EN])
			ciph_off_reg <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			auth_en_reg <= PCTL_RESET[BIT_AUTH_EN];
		else if (hit_wr && (bus.wdata[BIT_RESET] || bus.wdata[BIT_AUTH_DIS]))
			auth_en_reg <= 1'b0;
		else if (hit_wr && bus.wdata[BIT_AUTH_EN])
			auth_en_reg <= 1'b1;
	end
	assign auth_enabled = auth_en_reg;
	assign cipher_active = (ciph_en_reg || always_pol) && !ciph_off_reg;

	// reserved and pulse bits read zero
	always_comb
	begin
		rd_next = '0;
		rd_next[BIT_LIST_OK] = list_ok_reg;
		rd_next[BIT_KEY_OK] = key_ok_reg;
		rd_next[BIT_CIPH_EN] = ciph_en_reg || always_pol;
		rd_next[BIT_AUTH_EN] = auth_en_reg;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			rdata_reg <= PCTL_RESET;
		else if (bus.rd && bus.addr == PCTL_ADDR)
			rdata_reg <= rd_next;
		else if (bus.rd)
			rdata_reg <= '0;
	end
	assign rdata = rdata_reg;

	pctl_mux pctl_mux_inst (
		.core_clk(core_clk),
		.reset(reset),
		.cipher_enable(cipher_active),
		.authenticated(authenticated),
		.video_mode(video_mode)
	);

	a_reset_kills_auth: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && bus.wdata[BIT_RESET] |=> !auth_enabled && cmd.engine_reset) else $error("reset write failed");
	a_reset_pulse_one: assert property (@(posedge core_clk) disable iff (reset)
		cmd.engine_reset && !(hit_wr && bus.wdata[BIT_RESET]) |=> !cmd.engine_reset) else $error("reset stuck");
	a_list_clears: assert property (@(posedge core_clk) disable iff (reset)
		auth_complete && !hit_wr |=> !list_ok_reg) else $error("list approval not cleared");
	a_key_zero_write: assert property (@(posedge core_clk) disable iff (reset)
		key_ok_reg && hit_wr && !bus.wdata[BIT_KEY_OK] && !bus.wdata[BIT_RESET] && !ready_rise |=> key_ok_reg)
		else $error("key approval lost");
	a_key_ready_clr: assert property (@(posedge core_clk) disable iff (reset)
		ready_rise && !hit_wr |=> !key_ok_reg) else $error("key approval held");
	a_off_keeps_auth: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && bus.wdata == 8'h00_08 |=> !cipher_active && auth_enabled == $past(auth_enabled))
		else $error("cipher off wrong");
	a_always_reads_one: assert property (@(posedge core_clk) disable iff (reset)
		always_pol && bus.rd && bus.addr == PCTL_ADDR |=> rdata[BIT_CIPH_EN]) else $error("enable not one");
	a_auth_disable: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && bus.wdata[BIT_AUTH_DIS] |=> !auth_enabled ##1 !cmd.auth_disable || $past(hit_wr))
		else $error("auth disable failed");
	a_auth_start: assert property (@(posedge core_clk) disable iff (reset)
		hit_wr && bus.wdata == 8'h00_01 |=> auth_enabled && cmd.auth_start) else $error("auth start failed");
	a_rsvd_zero: assert property (@(posedge core_clk) disable iff (reset)
		!rdata[BIT_RSVD] && !rdata[BIT_RESET]) else $error("reserved bit set");
endmodule // pctl_regs

// file: inc/pctl_pkg.sv
// package for the protection control register bank
// assumes one core clock domain and a byte-wide register port
package pctl_pkg;
	localparam logic [7:0] PCTL_ADDR = 8'h00_C3;
	localparam logic [7:0] PCTL_RESET = 8'h00_00;
	localparam int BIT_RESET = 7;
	localparam int BIT_RSVD = 6;
	localparam int BIT_LIST_OK = 5;
	localparam int BIT_KEY_OK = 4;
	localparam int BIT_CIPH_OFF = 3;
	localparam int BIT_CIPH_EN = 2;
	localparam int BIT_AUTH_DIS = 1;
	localparam int BIT_AUTH_EN = 0;
	localparam logic [1:0] POL_AUTH_ONLY = 2'h0;
	localparam logic [1:0] POL_REG_CTRL = 2'h1;
	localparam logic [1:0] POL_ALWAYS = 2'h2;
	localparam logic [1:0] POL_INBAND = 2'h3;

	typedef enum logic [1:0] {PCTL_VID_PLAIN, PCTL_VID_CIPHER, PCTL_VID_BLUE} pctl_video_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pctl_bus_t;

	typedef struct packed {
		logic engine_reset;
		logic auth_start;
		logic auth_disable;
		logic cipher_off;
		logic list_approved;
		logic key_approved;
	} pctl_cmd_t;
endpackage

// file: src/pctl_mux.sv
// video mode selection from encryption enable and authentication state
// assumes inputs on core_clk
`timescale 1ns/100ps
module pctl_mux (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cipher_enable,
	input wire logic authenticated,
	output pctl_pkg::pctl_video_t video_mode
);
	import pctl_pkg::*;
	pctl_video_t mode_reg;
	pctl_video_t mode_next;
	always_comb
	begin
		if (cipher_enable && authenticated)
			mode_next = PCTL_VID_CIPHER;
		else if (cipher_enable)
			mode_next = PCTL_VID_BLUE;
		else
			mode_next = PCTL_VID_PLAIN;
	end
	always_ff @(posedge core_clk)
	begin
		if (reset)
			mode_reg <= PCTL_VID_PLAIN;
		else
			mode_reg <= mode_next;
	end
	assign video_mode = mode_reg;

	a_blue_when_unauth: assert property (@(posedge core_clk) disable iff (reset)
		cipher_enable && !authenticated |=> video_mode == PCTL_VID_BLUE) else $error("blue screen missing");
	a_cipher_when_auth: assert property (@(posedge core_clk) disable iff (reset)
		cipher_enable && authenticated |=> video_mode == PCTL_VID_CIPHER) else $error("cipher missing");
	a_plain_when_off: assert property (@(posedge core_clk) disable iff (reset)
		!cipher_enable |=> video_mode == PCTL_VID_PLAIN) else $error("plain video missing");
endmodule // pctl_mux

// file: tb/pctl_regs_tb.sv
// testbench for the protection control register bank
// drives the register port and engine status inputs directly
`timescale 1ns/100ps
module pctl_regs_tb;
	import pctl_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	pctl_bus_t bus = '0;
	logic [1:0] cipher_policy = 2'h0;
	logic receiver_key_ready = 1'b0;
	logic auth_complete = 1'b0;
	logic authenticated = 1'b0;
	logic [7:0] rdata;
	pctl_cmd_t cmd;
	logic auth_enabled;
	logic cipher_active;
	pctl_video_t video_mode;
	int n_errors = 0;
	int check_count = 0;
	always #10 core_clk = ~core_clk;
	pctl_regs pctl_regs_inst (.core_clk(core_clk), .reset(reset), .bus(bus), .rdata(rdata),
		.cipher_policy(cipher_policy), .receiver_key_ready(receiver_key_ready),
		.auth_complete(auth_complete), .authenticated(authenticated), .cmd(cmd),
		.auth_enabled(auth_enabled), .cipher_active(cipher_active), .video_mode(video_mode));
	task automatic step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic chk1(input string name, input logic seen, input logic exp);
		check(name, {7'h00, seen}, {7'h00, exp});
	endtask
	task automatic chkv(input pctl_video_t exp);
		check("video_mode", {6'h00, video_mode}, {6'h00, exp});
	endtask
	// gap edge first so no bus field is set twice in one step
	task automatic wr(input logic [7:0] v, input logic [7:0] a = PCTL_ADDR);
		step(1);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = v;
		step(1);
		bus.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] exp);
		step(1);
		bus.rd = 1'b1;
		bus.addr = PCTL_ADDR;
		step(1);
		bus.rd = 1'b0;
		check("rdata", rdata, exp);
	endtask
	task automatic do_reset();
		reset = 1'b1;
		step(4);
		reset = 1'b0;
	endtask
	task automatic t_auth();
		rd(8'h00);
		check("cmd", {2'h0, cmd}, 8'h00);
		wr(8'h01);
		chk1("auth_start", cmd.auth_start, 1'b1);
		chk1("auth_enabled", auth_enabled, 1'b1);
		step(1);
		chk1("auth_start", cmd.auth_start, 1'b0);
		wr(8'h00);
		rd(8'h01);
		wr(8'h01);
		chk1("auth_start", cmd.auth_start, 1'b1);
		wr(8'h02);
		chk1("auth_disable", cmd.auth_disable, 1'b1);
		step(1);
		chk1("auth_enabled", auth_enabled, 1'b0);
		rd(8'h00);
	endtask
	task automatic t_approve();
		wr(8'h30);
		step(1);
		chk1("key_approved", cmd.key_approved, 1'b1);
		chk1("list_approved", cmd.list_approved, 1'b1);
		wr(8'h20);
		rd(8'h30);
		receiver_key_ready = 1'b1;
		rd(8'h20);
		auth_complete = 1'b1;
		step(1);
		auth_complete = 1'b0;
		receiver_key_ready = 1'b0;
		rd(8'h00);
		chk1("list_approved", cmd.list_approved, 1'b0);
	endtask
	task automatic t_cipher();
		wr(8'h05);
		step(1);
		chkv(PCTL_VID_BLUE);
		authenticated = 1'b1;
		step(2);
		chkv(PCTL_VID_CIPHER);
		wr(8'h08);
		chk1("cipher_off", cmd.cipher_off, 1'b1);
		step(1);
		chkv(PCTL_VID_PLAIN);
		chk1("auth_enabled", auth_enabled, 1'b1);
		wr(8'h04);
		step(1);
		chkv(PCTL_VID_CIPHER);
		wr(8'h00);
		step(1);
		chkv(PCTL_VID_PLAIN);
		chk1("cipher_active", cipher_active, 1'b0);
		authenticated = 1'b0;
	endtask
	task automatic t_policy();
		cipher_policy = POL_ALWAYS;
		wr(8'h00);
		rd(8'h04);
		chk1("cipher_active", cipher_active, 1'b1);
		cipher_policy = POL_INBAND;
		rd(8'h00);
		cipher_policy = POL_REG_CTRL;
		rd(8'h00);
		cipher_policy = POL_AUTH_ONLY;
	endtask
	task automatic t_resetbit();
		wr(8'h35);
		wr(8'hC0);
		chk1("engine_reset", cmd.engine_reset, 1'b1);
		rd(8'h00);
		chk1("auth_enabled", auth_enabled, 1'b0);
		wr(8'h41);
		rd(8'h01);
		do_reset();
		wr(8'h01, 8'hC2);
		rd(8'h00);
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		#100000;
		n_errors++;
		conclude();
	end
	initial
	begin
		do_reset();
		t_auth();
		t_approve();
		do_reset();
		t_cipher();
		do_reset();
		t_policy();
		t_resetbit();
		conclude();
	end
endmodule // pctl_regs_tb
